// *** pmc_map.vh ***
// register offsets, field positions, reset values and codes of the power mode control
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// register byte offsets
`define PMC_OFF_CTRL 4'h0
`define PMC_OFF_STATE 4'h4
`define PMC_OFF_STATUS 4'h8
`define PMC_OFF_MASK 4'hC

// control register fields
`define PMC_CTRL_STBY 7
`define PMC_CTRL_WAIT_HI 6
`define PMC_CTRL_WAIT_LO 4
`define PMC_CTRL_LSPD 3
`define PMC_CTRL_MSPD 2
`define PMC_CTRL_DIRECT 1
`define PMC_CTRL_TBASE 0
`define PMC_CTRL_RESET 8'h00

// status and mask fields
`define PMC_EV_SLEEP 0
`define PMC_EV_WAKE 1
`define PMC_EV_SETTLED 2
`define PMC_EV_IGNORED 3
`define PMC_EV_W 4
`define PMC_MASK_RESET 4'h0

// operating states
`define PMC_ST_ACT_HI 4'h0
`define PMC_ST_ACT_MED 4'h1
`define PMC_ST_SLP_HI 4'h2
`define PMC_ST_SLP_MED 4'h3
`define PMC_ST_WATCH 4'h4
`define PMC_ST_SUBACT 4'h5
`define PMC_ST_SUBSLP 4'h6
`define PMC_ST_STANDBY 4'h7
`define PMC_ST_SETTLE 4'h8

// interrupt source vector layout
`define PMC_SRC_W 24
`define PMC_SRC_TMR_A 0
`define PMC_SRC_TMR_C 1
`define PMC_SRC_TMR_F 2
`define PMC_SRC_TMR_G 3
`define PMC_SRC_SER1 4
`define PMC_SRC_SER2 5
`define PMC_SRC_EXT_LO 6
`define PMC_SRC_WKP_LO 11
`define PMC_SRC_AEC 19

// wake-up source classes over the source vector
`define PMC_CLASS_WATCH 24'h07F84D
`define PMC_CLASS_SUB 24'h0FFFFF
`define PMC_CLASS_ALL 24'hFFFFFF
`define PMC_CLASS_STBY 24'h07F8C0

// external line enables per state (bit 0 is line 0)
`define PMC_EXT_ALL 5'h1F
`define PMC_EXT_WATCH 5'h01
`define PMC_EXT_STBY 5'h03

// settle wait counts in states
`define PMC_WAIT_BASE 18'h02000
`define PMC_WAIT_CODE5 18'h00002
`define PMC_WAIT_CODE6 18'h00008
`define PMC_WAIT_CODE7 18'h00010

`endif

// *** pmc_settle_timer.v ***
// oscillator settling wait counter of the power mode control
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.vh"

module pmc_settle_timer #(
  parameter CNT_W = 18,
  parameter [17:0] WAIT_BASE = `PMC_WAIT_BASE
) (
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire [2:0] wait_code,
  output reg done_reg
);

  reg [CNT_W-1:0] cnt_reg;
  reg busy_reg;

  // wait length for a three-bit code
  function [CNT_W-1:0] wait_len;
    input [2:0] code;
    begin
      case (code)
        3'h5: wait_len = `PMC_WAIT_CODE5;
        3'h6: wait_len = `PMC_WAIT_CODE6;
        3'h7: wait_len = `PMC_WAIT_CODE7;
        default: wait_len = WAIT_BASE << code;
      endcase
    end
  endfunction

  // load on start, count down, one-cycle done when the last state passes
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= {CNT_W{1'b0}};
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (start)
      begin
        cnt_reg <= wait_len(wait_code) - 1'b1;
        busy_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
        if (cnt_reg == {CNT_W{1'b0}})
        begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule // pmc_settle_timer
`default_nettype wire

// *** pmc_power_mode_control.v ***
// operating mode controller: sleep decode, wake classes, clock and line gating, registers
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.vh"

module pmc_power_mode_control #(
  parameter [17:0] WAIT_BASE = `PMC_WAIT_BASE
) (
  input wire clk_sys,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_reg,
  input wire sleep_exec,
  input wire int_accept,
  input wire [23:0] int_source,
  output reg [3:0] mode_state_reg,
  output reg sys_osc_run_reg,
  output reg cpu_run_reg,
  output reg cpu_on_subclock_reg,
  output reg [4:0] ext_line_enable_reg,
  output reg serial_reset_reg,
  output reg irq_reg
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg [7:0] ctrl_reg;
  reg [`PMC_EV_W-1:0] status_reg;
  reg [`PMC_EV_W-1:0] mask_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg settle_start;
  reg [`PMC_EV_W-1:0] ev_set;
  wire settle_done;
  wire stby_sel = ctrl_reg[`PMC_CTRL_STBY];
  wire lspd_sel = ctrl_reg[`PMC_CTRL_LSPD];
  wire mspd_sel = ctrl_reg[`PMC_CTRL_MSPD];
  wire direct_sel = ctrl_reg[`PMC_CTRL_DIRECT];
  wire tbase_sel = ctrl_reg[`PMC_CTRL_TBASE];
  wire [4:0] ext_en_now;
  wire [23:0] src_live;
  wire held_hit;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // external lines that work in a state; line 0 always
  function [4:0] ext_enable;
    input [3:0] st;
    begin
      case (st)
        `PMC_ST_WATCH: ext_enable = `PMC_EXT_WATCH;
        `PMC_ST_STANDBY: ext_enable = `PMC_EXT_STBY;
        default: ext_enable = `PMC_EXT_ALL;
      endcase
    end
  endfunction

  // wake class mask of a low-power state
  function [23:0] wake_class;
    input [3:0] st;
    begin
      case (st)
        `PMC_ST_WATCH: wake_class = `PMC_CLASS_WATCH;
        `PMC_ST_SUBSLP: wake_class = `PMC_CLASS_SUB;
        `PMC_ST_STANDBY: wake_class = `PMC_CLASS_STBY;
        `PMC_ST_SLP_HI: wake_class = `PMC_CLASS_ALL;
        `PMC_ST_SLP_MED: wake_class = `PMC_CLASS_ALL;
        default: wake_class = 24'h000000;
      endcase
    end
  endfunction

  // target of a sleep instruction from the control bits
  function [3:0] sleep_target;
    input [3:0] st;
    input l;
    input m;
    input s;
    input t;
    input d;
    reg from_sub;
    begin
      from_sub = (st == `PMC_ST_SUBACT);
      if (d)
      begin
        // direct transfer among the running states
        if (l && s && t)
          sleep_target = `PMC_ST_SUBACT;
        else if (m)
          sleep_target = `PMC_ST_ACT_MED;
        else
          sleep_target = `PMC_ST_ACT_HI;
      end
      else if (s)
      begin
        if (from_sub || t)
          sleep_target = `PMC_ST_WATCH;
        else
          sleep_target = `PMC_ST_STANDBY;
      end
      else if (from_sub)
        sleep_target = `PMC_ST_SUBSLP;
      else if (m)
        sleep_target = `PMC_ST_SLP_MED;
      else
        sleep_target = `PMC_ST_SLP_HI;
    end
  endfunction

  // ----------------------------------------------------------------
  // interrupt source gating
  // ----------------------------------------------------------------

  // held lines drop their accepted requests
  assign ext_en_now = ext_enable(state_reg);
  assign src_live = int_source & {{(24 - `PMC_SRC_EXT_LO - 5){1'b1}}, ext_en_now,
                                  {`PMC_SRC_EXT_LO{1'b1}}};
  assign held_hit = int_accept && (int_source != src_live);

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------

  // next state, only a sleep, an accepted interrupt or the end of settling moves it
  always @*
  begin
    state_next = state_reg;
    settle_start = 1'b0;
    ev_set = {`PMC_EV_W{1'b0}};
    ev_set[`PMC_EV_IGNORED] = held_hit;
    ev_set[`PMC_EV_SETTLED] = settle_done && (state_reg == `PMC_ST_SETTLE);
    case (state_reg)
      `PMC_ST_ACT_HI, `PMC_ST_ACT_MED, `PMC_ST_SUBACT:
      begin
        if (sleep_exec)
        begin
          state_next = sleep_target(state_reg, lspd_sel, mspd_sel, stby_sel, tbase_sel, direct_sel);
          ev_set[`PMC_EV_SLEEP] = 1'b1;
        end
      end
      `PMC_ST_SLP_HI:
      begin
        if (int_accept && ((src_live & wake_class(state_reg)) != 24'h000000))
        begin
          state_next = `PMC_ST_ACT_HI;
          ev_set[`PMC_EV_WAKE] = 1'b1;
        end
      end
      `PMC_ST_SLP_MED:
      begin
        if (int_accept && ((src_live & wake_class(state_reg)) != 24'h000000))
        begin
          state_next = `PMC_ST_ACT_MED;
          ev_set[`PMC_EV_WAKE] = 1'b1;
        end
      end
      `PMC_ST_WATCH, `PMC_ST_SUBSLP, `PMC_ST_STANDBY:
      begin
        if (int_accept && ((src_live & wake_class(state_reg)) != 24'h000000))
        begin
          ev_set[`PMC_EV_WAKE] = 1'b1;
          if (lspd_sel && (state_reg != `PMC_ST_STANDBY))
            state_next = `PMC_ST_SUBACT;
          else
          begin
            state_next = `PMC_ST_SETTLE;
            settle_start = 1'b1;
          end
        end
      end
      `PMC_ST_SETTLE:
      begin
        if (settle_done)
          state_next = mspd_sel ? `PMC_ST_ACT_MED : `PMC_ST_ACT_HI;
      end
      default:
        state_next = `PMC_ST_ACT_HI;
    endcase
  end

  // state register and the outputs it decodes
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= `PMC_ST_ACT_HI;
      mode_state_reg <= `PMC_ST_ACT_HI;
      sys_osc_run_reg <= 1'b1;
      cpu_run_reg <= 1'b1;
      cpu_on_subclock_reg <= 1'b0;
      ext_line_enable_reg <= `PMC_EXT_ALL;
      serial_reset_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_state_reg <= state_next;
      // oscillator stops in watch, subactive, subsleep, standby
      sys_osc_run_reg <= (state_next != `PMC_ST_WATCH) && (state_next != `PMC_ST_SUBACT) &&
                         (state_next != `PMC_ST_SUBSLP) && (state_next != `PMC_ST_STANDBY);
      cpu_run_reg <= (state_next == `PMC_ST_ACT_HI) || (state_next == `PMC_ST_ACT_MED) ||
                     (state_next == `PMC_ST_SUBACT);
      cpu_on_subclock_reg <= (state_next == `PMC_ST_SUBACT);
      ext_line_enable_reg <= ext_enable(state_next);
      serial_reset_reg <= (state_next == `PMC_ST_WATCH) || (state_next == `PMC_ST_STANDBY);
    end
  end

  // ----------------------------------------------------------------
  // settling timer
  // ----------------------------------------------------------------
  pmc_settle_timer #(
    .CNT_W(18),
    .WAIT_BASE(WAIT_BASE)
  ) u_settle (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(settle_start),
    .wait_code(ctrl_reg[`PMC_CTRL_WAIT_HI:`PMC_CTRL_WAIT_LO]),
    .done_reg(settle_done)
  );

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------

  // writes: control, mask, write-one-to-clear status; set wins
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= `PMC_CTRL_RESET;
      mask_reg <= `PMC_MASK_RESET;
      status_reg <= {`PMC_EV_W{1'b0}};
    end
    else
    begin
      if (reg_wr && (reg_addr == `PMC_OFF_CTRL))
        ctrl_reg <= reg_wdata;
      if (reg_wr && (reg_addr == `PMC_OFF_MASK))
        mask_reg <= reg_wdata[`PMC_EV_W-1:0];
      if (reg_wr && (reg_addr == `PMC_OFF_STATUS))
        status_reg <= (status_reg & ~reg_wdata[`PMC_EV_W-1:0]) | ev_set;
      else
        status_reg <= status_reg | ev_set;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata_reg <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `PMC_OFF_CTRL: reg_rdata_reg <= ctrl_reg;
        `PMC_OFF_STATE: reg_rdata_reg <= {4'h0, state_reg};
        `PMC_OFF_STATUS: reg_rdata_reg <= {4'h0, status_reg};
        `PMC_OFF_MASK: reg_rdata_reg <= {4'h0, mask_reg};
        default: reg_rdata_reg <= 8'h00;
      endcase
    end
    else
      reg_rdata_reg <= 8'h00;
  end

  // level interrupt from unmasked sticky events
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_reg & mask_reg);
  end

endmodule // pmc_power_mode_control
`default_nettype wire

// *** pmc_power_mode_control_chk.sv ***
// assertion checker of the power mode control
`timescale 1ns/1ps
`default_nettype none
module pmc_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic sleep_exec,
  input wire logic int_accept,
  input wire logic [23:0] int_source,
  input wire logic [3:0] mode_state_reg,
  input wire logic sys_osc_run_reg,
  input wire logic cpu_on_subclock_reg,
  input wire logic [4:0] ext_line_enable_reg
);
  // ------------
  // properties
  // ------------
  logic [7:0] ctl_reg;
  wire logic [3:0] st = mode_state_reg;
  wire logic wk = int_accept;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // shadow of the control register
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      ctl_reg <= 8'h00;
    else if (reg_wr && reg_addr == 4'h0)
      ctl_reg <= reg_wdata;
  chk_osc_halt: assert property (st > 4'h3 && st < 4'h8 |-> !sys_osc_run_reg)
    else $error("oscillator running in low power state");
  chk_state_hold: assert property (!sleep_exec && !wk && st != 4'h8 |=> $stable(st))
    else $error("state changed without cause");
  chk_sleep_decode: assert property (sleep_exec && st == 4'h0 && ctl_reg == 8'h00 |=> st == 4'h2)
    else $error("plain sleep not entered");
  chk_stby_entry: assert property (sleep_exec && st < 4'h2 && ctl_reg[7] && ctl_reg[1:0] == 2'h0 |=> st == 4'h7)
    else $error("standby not entered");
  chk_watch_class: assert property (st == 4'h4 && wk && !(|(int_source & 24'h07F84D)) |=> st == 4'h4)
    else $error("watch left by foreign source");
  chk_pin_wake: assert property (st == 4'h7 && wk && |int_source[18:11] |=> st == 4'h8)
    else $error("pin did not wake standby");
  chk_held_lines: assert property (st == 4'h7 |-> ext_line_enable_reg == 5'h03)
    else $error("standby line gating wrong");
  chk_line0_live: assert property (ext_line_enable_reg[0])
    else $error("line zero disabled");
  chk_sub_clock: assert property (cpu_on_subclock_reg == (st == 4'h5))
    else $error("cpu clock choice wrong");
  chk_settle_len: assert property (st == 4'h7 && wk && int_source[11] && ctl_reg[6:4] == 3'h5
    |=> st == 4'h8 ##[2:4] st < 4'h2)
    else $error("short settle wait wrong");
  cov_subsleep: cover property (st == 4'h6);
  cov_settle: cover property (st == 4'h8);
  cov_sub_sleep: cover property (sleep_exec && st == 4'h5);
endmodule // pmc_chk
bind pmc_power_mode_control pmc_chk pmc_chk_i (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .sleep_exec, .int_accept, .int_source, .mode_state_reg, .sys_osc_run_reg, .cpu_on_subclock_reg,
  .ext_line_enable_reg);
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the power mode control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------
  // stimulus
  // ----------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_exec = 1'b0;
  logic int_accept = 1'b0;
  logic [23:0] int_source = 24'h000000;
  logic [7:0] reg_rdata_reg;
  logic [3:0] mode_state_reg;
  logic sys_osc_run_reg, cpu_run_reg, cpu_on_subclock_reg, serial_reset_reg, irq_reg;
  logic [4:0] ext_line_enable_reg;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int settle_n = 0;
  // control, state after sleep, wake source, state after wake
  logic [39:0] rows [11] = '{{8'h00, 4'h2, 24'h000001, 4'h0}, {8'h04, 4'h3, 24'h800000, 4'h1},
    {8'h06, 4'h1, 24'h000000, 4'h1}, {8'h02, 4'h0, 24'h000000, 4'h0}, {8'h81, 4'h4, 24'h000040, 4'h0},
    {8'h8B, 4'h5, 24'h000000, 4'h5}, {8'h08, 4'h6, 24'h000002, 4'h5}, {8'h88, 4'h4, 24'h000002, 4'h4},
    {8'h88, 4'h4, 24'h000004, 4'h5}, {8'h52, 4'h0, 24'h000000, 4'h0}, {8'hE5, 4'h4, 24'h000040, 4'h1}};
  pmc_power_mode_control #(.WAIT_BASE(18'h00010)) pmc_power_mode_control_i (.clk_sys, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_reg, .sleep_exec, .int_accept, .int_source, .mode_state_reg,
    .sys_osc_run_reg, .cpu_run_reg, .cpu_on_subclock_reg, .ext_line_enable_reg, .serial_reset_reg, .irq_reg);
  // clock and hang guard
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      give_verdict;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_reg, e);
  endtask
  task pulse(input logic s, input logic [23:0] src);
    @(posedge clk_sys);
    sleep_exec <= s;
    int_accept <= !s;
    int_source <= src;
    @(posedge clk_sys);
    sleep_exec <= 1'b0;
    int_accept <= 1'b0;
    #1;
  endtask
  task expect_state(input logic [3:0] e);
    check({mode_state_reg, sys_osc_run_reg, cpu_run_reg, cpu_on_subclock_reg, serial_reset_reg,
      ext_line_enable_reg}, {e, e < 4'h4 || e == 4'h8, e < 4'h2 || e == 4'h5, e == 4'h5,
      e == 4'h4 || e == 4'h7, e == 4'h4 ? 5'h01 : e == 4'h7 ? 5'h03 : 5'h1F});
  endtask
  // wait out settling, sampling each state after its edge has settled
  task settle_out;
    settle_n = 0;
    while (mode_state_reg === 4'h8 && settle_n < 200)
    begin
      @(posedge clk_sys);
      #1;
      settle_n++;
    end
    #1;
  endtask
  // table run, then reset and awkward cases
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(4'h0, rows[i][39:32]);
      pulse(1'b1, 24'h000000);
      expect_state(rows[i][31:28]);
      if (rows[i][27:4] != 24'h000000)
      begin
        pulse(1'b0, rows[i][27:4]);
        settle_out;
        expect_state(rows[i][3:0]);
      end
    end
    $display("test mode table done");
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    expect_state(4'h0);
    rd(4'h0, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'hC, 8'h00);
    $display("test reset done");
    wr(4'hC, 8'h01);
    wr(4'h0, 8'hD0);
    pulse(1'b1, 24'h000000);
    expect_state(4'h7);
    @(posedge clk_sys);
    #1;
    check(irq_reg, 1'b1);
    pulse(1'b0, 24'h000100);
    expect_state(4'h7);
    rd(4'h8, 8'h09);
    pulse(1'b0, 24'h000800);
    check(mode_state_reg, 4'h8);
    settle_out;
    // two wait states, then one cycle for the done pulse
    check(settle_n, 32'h00000003);
    expect_state(4'h0);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h0F);
    wr(4'h8, 8'h0F);
    rd(4'h8, 8'h00);
    check(irq_reg, 1'b0);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h00);
    rd(4'h0, 8'hD0);
    $display("test standby done");
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
